// [verilog/scd_pkg.sv]
// package for the static column dram controller
package scd_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned ROW_BITS         = 10;
  localparam int unsigned COL_BITS         = 10;
  localparam int unsigned REFRESH_ROWS     = 512;
  localparam int unsigned REFRESH_PERIOD_NS = 15600;
  localparam int unsigned REFRESH_CYC      = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_NS       = 200000;
  localparam int unsigned POWERUP_CYC      = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IDLE_LIMIT_NS    = 4000000;
  localparam int unsigned IDLE_LIMIT_CYC   = IDLE_LIMIT_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYCLES      = 8;
  localparam int unsigned CBR_INIT_CYCLES  = 8;
  // strobe phase lengths in cycles
  localparam int unsigned ROW_PRECHARGE_NS = 90;
  localparam int unsigned ROW_PRECHARGE_CYC =
    (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ROW_ACCESS_NS    = 120;
  localparam int unsigned ROW_ACCESS_CYC   = (ROW_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COL_STORE_NS     = 50;
  localparam int unsigned COL_STORE_CYC    = (COL_STORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COL_ACCESS_NS    = 60;
  localparam int unsigned COL_ACCESS_CYC   = (COL_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ROW_PULSE_NS     = 120;
  localparam int unsigned ROW_PULSE_CYC    = (ROW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W            = 24;

  typedef enum logic [2:0] {
    SCD_OP_READ  = 3'h0,
    SCD_OP_WRITE = 3'h1,
    SCD_OP_RMW   = 3'h2,
    SCD_OP_RWW   = 3'h3,
    SCD_OP_CTEST = 3'h4
  } scd_op_t;

  typedef struct packed {
    scd_op_t               op;
    logic [ROW_BITS-1:0]   row;
    logic [COL_BITS-1:0]   col;
    logic                  wdata;
    logic                  keep_open;
  } scd_req_t;

  typedef struct packed {
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic [ROW_BITS-1:0]   addr;
    logic                  din;
  } scd_pins_t;
endpackage

// [verilog/scd_ctrl.sv]
// host controller driving a static column dram through its strobes
`timescale 1ns/100ps
// Summary of operation
// - read-modify-write: write strobe after row access
// - read-while-write: write after column-to-store delay
// - static column: both strobes held low
// - row then column; later columns faster
// - refresh one row every 15.6 us
// - row-only refresh keeps column strobe high
// - hidden refresh: column low, precharge, refresh (code raises the column strobe before the ST_HID_PRE precharge)
// - eight column-before-row cycles before counter test
// - counter test sequence run by software
// - test select held low normally
// - 200 us pause, eight wake cycles
// - ten-bit row then ten-bit column address
module scd_ctrl #(
  parameter int unsigned POWERUP_CYC  = scd_pkg::POWERUP_CYC,
  parameter int unsigned IDLE_CYC     = scd_pkg::IDLE_LIMIT_CYC,
  parameter int unsigned REFRESH_CYC  = scd_pkg::REFRESH_CYC
) (
  // clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              SRST,
  // request side
  input  wire scd_pkg::scd_req_t REQ,
  input  wire logic              REQ_VALID,
  input  wire logic              RAW_REFRESH,
  output logic                   REQ_READY,
  output logic                   RDATA,
  output logic                   RDATA_VALID,
  output logic                   INIT_DONE,
  // memory pins
  output scd_pkg::scd_pins_t     PINS,
  output logic                   TEST_SELECT_PIN,
  input  wire logic              DQ_IN
);
  typedef enum {
    ST_POWERUP, ST_WAKE_LO, ST_WAKE_HI, ST_CBR_CAS, ST_CBR_RAS, ST_IDLE, ST_ROW,
    ST_COL, ST_ACCESS, ST_OPEN, ST_PRECHARGE, ST_ROF, ST_HID_PRE
  } scd_state_t;

  scd_state_t                   state_ff, nxt_state;
  logic [scd_pkg::CNT_W-1:0]    tmr_ff, nxt_tmr;
  logic [scd_pkg::CNT_W-1:0]    ref_ff, nxt_ref;
  logic [scd_pkg::CNT_W-1:0]    idle_ff, nxt_idle;
  logic [3:0]                   wake_ff, nxt_wake;
  logic                         ref_due_ff, nxt_ref_due;
  logic                         init_ff, nxt_init;
  logic                         ctest_ok_ff, nxt_ctest_ok;
  scd_pkg::scd_req_t            req_ff, nxt_req;
  scd_pkg::scd_pins_t           pins_ff, nxt_pins;
  logic                         rdy_ff, nxt_rdy;
  logic                         rd_ff, nxt_rd;
  logic                         rdv_ff, nxt_rdv;
  logic                         tsel_ff, nxt_tsel;

  assign PINS            = pins_ff;
  assign REQ_READY       = rdy_ff;
  assign RDATA           = rd_ff;
  assign RDATA_VALID     = rdv_ff;
  assign INIT_DONE       = init_ff;
  assign TEST_SELECT_PIN = tsel_ff;

  always_comb begin
    nxt_state    = state_ff;
    nxt_tmr      = (tmr_ff != '0) ? tmr_ff - 1'b1 : tmr_ff;
    nxt_ref      = ref_ff;
    nxt_idle     = idle_ff;
    nxt_wake     = wake_ff;
    nxt_ref_due  = ref_due_ff;
    nxt_init     = init_ff;
    nxt_ctest_ok = ctest_ok_ff;
    nxt_req      = req_ff;
    nxt_pins     = pins_ff;
    nxt_rdy      = 1'b0;
    nxt_rd       = rd_ff;
    nxt_rdv      = 1'b0;
    nxt_tsel     = 1'b0;
    if (init_ff && ref_ff == '0) begin
      nxt_ref     = scd_pkg::CNT_W'(REFRESH_CYC - 1);
      nxt_ref_due = 1'b1;
    end else if (init_ff) begin
      nxt_ref = ref_ff - 1'b1;
    end
    if (pins_ff.ras_n && idle_ff != scd_pkg::CNT_W'(IDLE_CYC))
      nxt_idle = idle_ff + 1'b1;
    else if (!pins_ff.ras_n)
      nxt_idle = '0;
    case (state_ff)
      ST_POWERUP: begin
        if (tmr_ff == '0) begin
          nxt_wake  = 4'h0;
          nxt_state = ST_WAKE_LO;
          nxt_tmr   = scd_pkg::CNT_W'(scd_pkg::ROW_PULSE_CYC);
        end
      end
      ST_WAKE_LO: begin
        nxt_pins.ras_n = 1'b0;
        nxt_pins.cas_n = 1'b1;
        if (tmr_ff == '0) begin
          nxt_pins.ras_n = 1'b1;
          nxt_wake       = wake_ff + 1'b1;
          nxt_state      = ST_WAKE_HI;
          nxt_tmr        = scd_pkg::CNT_W'(scd_pkg::ROW_PRECHARGE_CYC);
        end
      end
      ST_WAKE_HI: begin
        if (tmr_ff == '0) begin
          nxt_tmr = scd_pkg::CNT_W'(scd_pkg::ROW_PULSE_CYC);
          if (wake_ff != 4'(scd_pkg::WAKE_CYCLES)) begin
            nxt_state = ST_WAKE_LO;
          end else begin
            nxt_wake  = 4'h0;
            nxt_state = ST_CBR_CAS;
            nxt_tmr   = scd_pkg::CNT_W'(1);
          end
        end
      end
      ST_CBR_CAS: begin
        nxt_pins.cas_n = 1'b0;
        nxt_pins.we_n  = 1'b1;
        if (tmr_ff == '0) begin
          nxt_state = ST_CBR_RAS;
          nxt_tmr   = scd_pkg::CNT_W'(scd_pkg::ROW_PULSE_CYC);
        end
      end
      ST_CBR_RAS: begin
        nxt_pins.ras_n = 1'b0;
        if (tmr_ff == '0) begin
          nxt_pins.ras_n = 1'b1;
          nxt_pins.cas_n = 1'b1;
          nxt_ref_due    = 1'b0;
          if (wake_ff != 4'(scd_pkg::CBR_INIT_CYCLES))
            nxt_wake = wake_ff + 1'b1;
          if (wake_ff == 4'(scd_pkg::CBR_INIT_CYCLES - 1))
            nxt_ctest_ok = 1'b1;
          nxt_state = ST_PRECHARGE;
          nxt_tmr   = scd_pkg::CNT_W'(scd_pkg::ROW_PRECHARGE_CYC);
          if (wake_ff < 4'(scd_pkg::CBR_INIT_CYCLES - 1) && !init_ff)
            nxt_state = ST_HID_PRE;
        end
      end
      ST_HID_PRE: begin
        nxt_pins.ras_n = 1'b1;
        if (tmr_ff == '0) begin
          nxt_state = ST_CBR_CAS;
          nxt_tmr   = scd_pkg::CNT_W'(1);
        end
      end
      ST_IDLE: begin
        nxt_init = 1'b1;
        if (idle_ff == scd_pkg::CNT_W'(IDLE_CYC)) begin
          nxt_init  = 1'b0;
          nxt_wake  = 4'h0;
          nxt_state = ST_WAKE_LO;
          nxt_tmr   = scd_pkg::CNT_W'(scd_pkg::ROW_PULSE_CYC);
        end else if (ref_due_ff && RAW_REFRESH) begin
          nxt_pins.ras_n = 1'b0;
          nxt_pins.cas_n = 1'b1;
          nxt_pins.addr  = ref_ff[scd_pkg::ROW_BITS-1:0];
          nxt_state      = ST_ROF;
          nxt_tmr        = scd_pkg::CNT_W'(scd_pkg::ROW_PULSE_CYC);
        end else if (ref_due_ff) begin
          nxt_state = ST_CBR_CAS;
          nxt_tmr   = scd_pkg::CNT_W'(1);
        end else if (REQ_VALID && (REQ.op != scd_pkg::SCD_OP_CTEST || ctest_ok_ff)) begin
          nxt_rdy = 1'b1;
          nxt_req = REQ;
          if (REQ.op == scd_pkg::SCD_OP_CTEST) begin
            nxt_pins.cas_n = 1'b0;
            nxt_pins.addr  = REQ.col;
            nxt_state      = ST_CBR_RAS;
            nxt_tmr        = scd_pkg::CNT_W'(1);
          end else begin
            nxt_pins.addr  = REQ.row;
            nxt_pins.ras_n = 1'b0;
            nxt_state      = ST_ROW;
            nxt_tmr        = scd_pkg::CNT_W'(1);
          end
        end
      end
      ST_ROF: begin
        if (tmr_ff == '0) begin
          nxt_pins.ras_n = 1'b1;
          nxt_ref_due    = 1'b0;
          nxt_state      = ST_PRECHARGE;
          nxt_tmr        = scd_pkg::CNT_W'(scd_pkg::ROW_PRECHARGE_CYC);
        end
      end
      ST_ROW: begin
        if (tmr_ff == '0) begin
          nxt_pins.addr  = req_ff.col;
          nxt_pins.cas_n = 1'b0;
          nxt_pins.we_n  = !(req_ff.op == scd_pkg::SCD_OP_WRITE);
          nxt_pins.din   = req_ff.wdata;
          nxt_state      = ST_COL;
          nxt_tmr        = scd_pkg::CNT_W'(scd_pkg::ROW_ACCESS_CYC);
          if (req_ff.op == scd_pkg::SCD_OP_RWW)
            nxt_tmr = scd_pkg::CNT_W'(scd_pkg::COL_STORE_CYC);
        end
      end
      ST_COL: begin
        if (tmr_ff == '0) begin
          nxt_rd  = DQ_IN;
          nxt_rdv = req_ff.op != scd_pkg::SCD_OP_WRITE;
          if (req_ff.op == scd_pkg::SCD_OP_RMW || req_ff.op == scd_pkg::SCD_OP_RWW)
            nxt_pins.we_n = 1'b0;
          nxt_state = ST_ACCESS;
          nxt_tmr   = scd_pkg::CNT_W'(1);
        end
      end
      ST_ACCESS: begin
        if (tmr_ff == '0) begin
          nxt_pins.we_n = 1'b1;
          // both strobes low for static column
          if (req_ff.keep_open) begin
            nxt_state = ST_OPEN;
          end else begin
            nxt_pins.ras_n = 1'b1;
            nxt_pins.cas_n = 1'b1;
            nxt_state      = ST_PRECHARGE;
            nxt_tmr        = scd_pkg::CNT_W'(scd_pkg::ROW_PRECHARGE_CYC);
          end
        end
      end
      ST_OPEN: begin
        if (ref_due_ff || !REQ_VALID || REQ.row != req_ff.row
            || REQ.op == scd_pkg::SCD_OP_CTEST) begin
          nxt_pins.ras_n = 1'b1;
          nxt_pins.cas_n = 1'b1;
          nxt_state      = ST_PRECHARGE;
          nxt_tmr        = scd_pkg::CNT_W'(scd_pkg::ROW_PRECHARGE_CYC);
        end else begin
          nxt_rdy        = 1'b1;
          nxt_req        = REQ;
          nxt_pins.addr  = REQ.col;
          nxt_pins.din   = REQ.wdata;
          nxt_pins.we_n  = !(REQ.op == scd_pkg::SCD_OP_WRITE);
          nxt_state      = ST_COL;
          nxt_tmr        = scd_pkg::CNT_W'(scd_pkg::COL_ACCESS_CYC);
        end
      end
      ST_PRECHARGE: begin
        if (tmr_ff == '0)
          nxt_state = init_ff ? ST_IDLE : ST_CBR_CAS;
        if (tmr_ff == '0 && !init_ff)
          nxt_tmr = scd_pkg::CNT_W'(1);
        if (tmr_ff == '0 && !init_ff && wake_ff == 4'(scd_pkg::CBR_INIT_CYCLES))
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_ff    <= ST_POWERUP;
      tmr_ff      <= scd_pkg::CNT_W'(POWERUP_CYC);
      ref_ff      <= '0;
      idle_ff     <= '0;
      wake_ff     <= 4'h0;
      ref_due_ff  <= 1'b0;
      init_ff     <= 1'b0;
      ctest_ok_ff <= 1'b0;
      req_ff      <= '0;
      pins_ff     <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: '0, din: 1'b0};
      rdy_ff      <= 1'b0;
      rd_ff       <= 1'b0;
      rdv_ff      <= 1'b0;
      tsel_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      tmr_ff      <= nxt_tmr;
      ref_ff      <= nxt_ref;
      idle_ff     <= nxt_idle;
      wake_ff     <= nxt_wake;
      ref_due_ff  <= nxt_ref_due;
      init_ff     <= nxt_init;
      ctest_ok_ff <= nxt_ctest_ok;
      req_ff      <= nxt_req;
      pins_ff     <= nxt_pins;
      rdy_ff      <= nxt_rdy;
      rd_ff       <= nxt_rd;
      rdv_ff      <= nxt_rdv;
      tsel_ff     <= nxt_tsel;
    end
  end
endmodule

// [tb/scd_ctrl_props.sv]
// port checker for the dram controller
`timescale 1ns/100ps
module scd_ctrl_props #(
  parameter int unsigned REFRESH_CYC = 50
) (
  // clock and reset
  input wire logic               SYS_CLK,
  input wire logic               SRST,
  // request side
  input wire logic               REQ_VALID,
  input wire logic               REQ_READY,
  input wire logic               RDATA_VALID,
  input wire logic               INIT_DONE,
  // memory pins
  input wire scd_pkg::scd_pins_t PINS,
  input wire logic               TEST_SELECT_PIN
);
  logic        seen_ff;
  logic        nxt_seen;
  logic [15:0] gap_ff;
  logic [15:0] nxt_gap;
  // cycles since the row strobe was last low
  always_comb begin
    nxt_seen = seen_ff | INIT_DONE;
    nxt_gap  = (!PINS.ras_n || !seen_ff) ? 16'h0 : gap_ff + 16'h1;
  end
  always_ff @(posedge SYS_CLK) begin
    seen_ff <= SRST ? 1'b0 : nxt_seen;
    gap_ff  <= SRST ? 16'h0 : nxt_gap;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  a_test_low: assert property (!TEST_SELECT_PIN)
    else $error("test select driven high");
  a_refresh_gap: assert property (gap_ff < REFRESH_CYC + 64)
    else $error("row strobe idle too long");
  a_precharge_len: assert property ($rose(PINS.ras_n) |-> PINS.ras_n[*4])
    else $error("row precharge too short");
  a_cbr_no_write: assert property ($fell(PINS.ras_n) && !PINS.cas_n |-> PINS.we_n)
    else $error("write strobe low in refresh");
  a_write_in_row: assert property (!PINS.we_n |-> !PINS.ras_n)
    else $error("write strobe outside row cycle");
  a_cas_after_row: assert property ($fell(PINS.cas_n) && !PINS.ras_n |-> !$past(PINS.ras_n))
    else $error("column strobe with row strobe");
  a_valid_cas: assert property (RDATA_VALID |-> !$past(PINS.cas_n) || !$past(PINS.cas_n, 2))
    else $error("read data without column strobe");
  a_valid_pulse: assert property (RDATA_VALID |=> !RDATA_VALID)
    else $error("read valid longer than one cycle");
  a_ready_cause: assert property (REQ_READY |-> $past(REQ_VALID) ##1 !REQ_READY)
    else $error("ready without request");
  c_cbr: cover property ($fell(PINS.ras_n) && !PINS.cas_n);
  c_write: cover property ($fell(PINS.we_n));
  c_read: cover property (RDATA_VALID);
endmodule
bind scd_ctrl scd_ctrl_props #(.REFRESH_CYC(REFRESH_CYC)) u_props (.SYS_CLK(SYS_CLK),
  .SRST(SRST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RDATA_VALID(RDATA_VALID),
  .INIT_DONE(INIT_DONE), .PINS(PINS), .TEST_SELECT_PIN(TEST_SELECT_PIN));

// [tb/scd_dram_model.sv]
// behavioural model of the static column dram
`timescale 1ns/100ps
module scd_dram_model (
  // sampling clock and pins
  input  wire logic               sys_clk,
  input  wire scd_pkg::scd_pins_t pins,
  input  wire logic               test_select_pin,
  output logic                    dq,
  // activity counts
  output int                      ras_cnt,
  output int                      cbr_cnt,
  output int                      ror_cnt
);
  bit         mem [int];
  logic [9:0] row = '0;
  logic [9:0] ctr = '0;
  logic       ras_q = 1'b1;
  logic       cbr = 1'b0;
  logic       seen = 1'b0;
  logic       rd = 1'b0;
  logic       dv = 1'b0;
  logic       tog = 1'b0;
  initial begin
    ras_cnt = 0;
    cbr_cnt = 0;
    ror_cnt = 0;
  end
  assign dq = (!pins.cas_n && dv && !test_select_pin) ? rd : tog;
  always @(posedge sys_clk) begin
    tog <= ~tog;
    if (pins.cas_n) dv <= 1'b0;
    if (ras_q && !pins.ras_n) begin
      ras_cnt++;
      seen = 1'b0;
      cbr = !pins.cas_n;
      // column-first fall takes the internal row counter
      if (cbr) begin
        cbr_cnt++;
        row = ctr;
        ctr++;
      end
      // row field latched on the row strobe
      else row = pins.addr;
    end
    if (!pins.ras_n && !pins.cas_n && !(cbr && pins.we_n)) begin
      seen = 1'b1;
      if (!pins.we_n) mem[{row, pins.addr}] = pins.din;
      // column follows address in open row
      else begin
        rd <= mem[{row, pins.addr}];
        dv <= 1'b1;
      end
    end
    // row-only cycle keeps column strobe high
    if (!ras_q && pins.ras_n && !seen && !cbr) ror_cnt++;
    ras_q = pins.ras_n;
  end
endmodule

// [tb/testbench.sv]
// self-checking bench for the dram controller
`timescale 1ns/100ps
module testbench;
  localparam scd_pkg::scd_op_t RD = scd_pkg::SCD_OP_READ;
  localparam scd_pkg::scd_op_t WR = scd_pkg::SCD_OP_WRITE;
  logic               sys_clk = 1'b0;
  logic               srst, req_valid, raw_refresh, req_ready, rdata, rdata_valid;
  logic               init_done, tsel, dq, q;
  scd_pkg::scd_req_t  req;
  scd_pkg::scd_pins_t pins;
  int                 fail_count = 0, tests_run = 0, cyc = 0, base;
  int                 ras_cnt, cbr_cnt, ror_cnt;
  always #12.5 sys_clk = ~sys_clk;
  scd_ctrl #(.POWERUP_CYC(20), .IDLE_CYC(2000), .REFRESH_CYC(50)) DUT (.SYS_CLK(sys_clk),
    .SRST(srst), .REQ(req), .REQ_VALID(req_valid), .RAW_REFRESH(raw_refresh),
    .REQ_READY(req_ready), .RDATA(rdata), .RDATA_VALID(rdata_valid), .INIT_DONE(init_done),
    .PINS(pins), .TEST_SELECT_PIN(tsel), .DQ_IN(dq));
  scd_dram_model u_mem (.sys_clk(sys_clk), .pins(pins), .test_select_pin(tsel), .dq(dq),
    .ras_cnt(ras_cnt), .cbr_cnt(cbr_cnt), .ror_cnt(ror_cnt));
  task automatic check(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic xfer(input scd_pkg::scd_op_t op, input logic [9:0] r, input logic [9:0] c,
                      input logic d, input logic k);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{op, r, c, d, k};
    req_valid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 400);
    req_valid <= 1'b0;
    check("request taken", 1'b1, n < 400);
    if (op != WR && op != scd_pkg::SCD_OP_CTEST) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (rdata_valid !== 1'b1 && n < 400);
      q = rdata;
      check("read answered", 1'b1, n < 400);
    end
  endtask
  task automatic t_init();
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    check("init done", 1'b1, init_done);
    check("wake row cycles", 1'b1, ras_cnt >= 16);
    check("column-first init cycles", 1'b1, cbr_cnt >= 8);
  endtask
  task automatic t_rw();
    xfer(WR, 10'h3ff, 10'h3ff, 1'b1, 1'b0);
    xfer(WR, 10'h000, 10'h3ff, 1'b0, 1'b0);
    xfer(RD, 10'h3ff, 10'h3ff, 1'b0, 1'b0);
    check("read top cell", 1'b1, q);
    xfer(RD, 10'h000, 10'h3ff, 1'b1, 1'b0);
    check("read low row", 1'b0, q);
  endtask
  task automatic t_static();
    xfer(WR, 10'h009, 10'h001, 1'b1, 1'b1);
    xfer(WR, 10'h009, 10'h002, 1'b0, 1'b1);
    xfer(RD, 10'h009, 10'h001, 1'b0, 1'b1);
    check("open row read one", 1'b1, q);
    xfer(RD, 10'h009, 10'h002, 1'b1, 1'b0);
    check("open row read two", 1'b0, q);
  endtask
  task automatic t_rmw();
    xfer(WR, 10'h004, 10'h004, 1'b0, 1'b0);
    xfer(scd_pkg::SCD_OP_RMW, 10'h004, 10'h004, 1'b1, 1'b0);
    check("modify old data", 1'b0, q);
    xfer(RD, 10'h004, 10'h004, 1'b0, 1'b0);
    check("modify new data", 1'b1, q);
    xfer(scd_pkg::SCD_OP_RWW, 10'h004, 10'h004, 1'b0, 1'b0);
    check("read-while-write old", 1'b1, q);
    xfer(RD, 10'h004, 10'h004, 1'b1, 1'b0);
    check("read-while-write new", 1'b0, q);
  endtask
  task automatic t_refresh();
    raw_refresh <= 1'b1;
    base = ror_cnt;
    repeat (300) @(posedge sys_clk);
    check("row-only refresh seen", 1'b1, ror_cnt > base);
    raw_refresh <= 1'b0;
    base = cbr_cnt;
    repeat (300) @(posedge sys_clk);
    check("column-first refresh seen", 1'b1, cbr_cnt > base);
    xfer(RD, 10'h3ff, 10'h3ff, 1'b0, 1'b0);
    check("data kept over refresh", 1'b1, q);
    base = cbr_cnt;
    // one counter test step of the software sequence
    xfer(scd_pkg::SCD_OP_CTEST, 10'h000, 10'h005, 1'b1, 1'b0);
    repeat (20) @(posedge sys_clk);
    check("counter test cycle", 1'b1, cbr_cnt > base);
  endtask
  initial begin
    srst = 1'b1;
    req_valid = 1'b0;
    raw_refresh = 1'b0;
    req = '0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_init();
    t_rw();
    t_static();
    t_rmw();
    t_refresh();
    finish_test();
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      finish_test();
    end
  end
endmodule
